// *** hw/flash_led_pkg.sv ***
// Shared constants and types for the flash LED control register bank
package flash_led_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h53;
    localparam int NUM_REGS = 6;
    localparam int IDX_GENERAL = 0;
    localparam int IDX_PIN = 1;
    localparam int IDX_STEP = 2;
    localparam int IDX_TORCH = 3;
    localparam int IDX_FLASH = 4;
    localparam int IDX_TIMEOUT = 5;
    localparam logic [NUM_REGS-1:0][7:0] REG_OFS = {8'hC0, 8'hB0, 8'hA0, 8'h50, 8'h20, 8'h10};
    localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {8'hF0, 8'h80, 8'h80, 8'hFC, 8'hE0, 8'h18};
    // Writable bits; the rest hold their fixed value
    localparam logic [NUM_REGS-1:0][7:0] WMASK = {8'h0F, 8'h7F, 8'h1F, 8'h03, 8'h1F, 8'h27};
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 1;
    localparam int BOOST_BIT = 2;
    localparam int FB_BIT = 5;
    localparam int PIN_FUNC_BIT = 0;
    localparam int PIN_DIR_BIT = 1;
    localparam int PIN_DATA_BIT = 2;
    localparam int OVP_BIT = 3;
    localparam int OCL_BIT = 4;
    localparam int TORCH_W = 5;
    localparam int FLASH_W = 7;
    localparam int TIMEOUT_W = 4;
    localparam int STEP_W = 2;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    localparam int STEP_BASE_US = 25;
    localparam int CLK_MHZ = 40;
    localparam int STEP_BASE_CYCLES = STEP_BASE_US * CLK_MHZ;
    localparam logic [6:0] MIN_LEVEL_CODE = 7'h04;
    typedef enum logic [1:0] {MODE_OFF = 2'h0, MODE_INDICATOR = 2'h1, MODE_TORCH = 2'h2, MODE_FLASH = 2'h3} led_mode_t;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_REG = 5'h04,
        ST_DATA = 5'h08,
        ST_SKIP = 5'h10
    } i2c_state_t;
    typedef struct packed {
        logic [7:0] regAddr;
        logic [7:0] data;
    } reg_write_t;
endpackage : flash_led_pkg

// *** hw/i2c_write_slave.sv ***
// Write-only two-wire slave that delivers register writes
`timescale 1ns/1ps
`default_nettype none
module i2c_write_slave (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic ackDrive,
    output logic writeCmd,
    output logic wrValid,
    output flash_led_pkg::reg_write_t wrPkt
);
    import flash_led_pkg::*;

    logic sclPrev_reg;
    logic sdaPrev_reg;
    logic [3:0] bitCnt_reg;
    logic [7:0] byteShift_reg;
    i2c_state_t state_reg;
    logic sclRise, sclFall, startSeen, stopSeen, byteDone, addrMatch, ackNeeded;

    assign sclRise = scl && !sclPrev_reg;
    assign sclFall = !scl && sclPrev_reg;
    assign startSeen = scl && sclPrev_reg && sdaPrev_reg && !sdaIn;
    assign stopSeen = scl && sclPrev_reg && !sdaPrev_reg && sdaIn;
    assign byteDone = sclFall && (bitCnt_reg == BYTE_BITS);
    assign addrMatch = (byteShift_reg == {SLAVE_ADDR, 1'b0});
    assign ackNeeded = (state_reg == ST_ADDR && addrMatch) || state_reg == ST_REG || state_reg == ST_DATA;

    always_ff @(posedge clk) begin
        sclPrev_reg <= sys_rst ? 1'b1 : scl;
        sdaPrev_reg <= sys_rst ? 1'b1 : sdaIn;
    end

    // Bits sampled on rising clock, MSB first
    always_ff @(posedge clk) begin
        if (sys_rst || startSeen || stopSeen) begin
            bitCnt_reg <= 4'h0;
        end else if (sclRise && bitCnt_reg < BYTE_BITS) begin
            byteShift_reg <= {byteShift_reg[6:0], sdaIn};
            bitCnt_reg <= bitCnt_reg + 4'h1;
        end else if (byteDone) begin
            bitCnt_reg <= ACK_SLOT;
        end else if (sclFall && bitCnt_reg == ACK_SLOT) begin
            bitCnt_reg <= 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || stopSeen) begin
            state_reg <= ST_IDLE;
        end else if (startSeen) begin
            state_reg <= ST_ADDR;
        end else if (byteDone) begin
            case (state_reg)
                ST_ADDR: state_reg <= addrMatch ? ST_REG : ST_SKIP;
                ST_REG: state_reg <= ST_DATA;
                default: state_reg <= state_reg;
            endcase
        end
    end

    // Data line held low from eighth fall to ninth fall
    always_ff @(posedge clk) begin
        if (sys_rst || startSeen || stopSeen) begin
            ackDrive <= 1'b0;
        end else if (byteDone) begin
            ackDrive <= ackNeeded;
        end else if (sclFall && bitCnt_reg == ACK_SLOT) begin
            ackDrive <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        writeCmd <= !sys_rst && byteDone && state_reg == ST_ADDR && addrMatch;
        wrValid <= !sys_rst && byteDone && state_reg == ST_DATA;
        if (sys_rst) begin
            wrPkt <= '0;
        end else if (byteDone && state_reg == ST_REG) begin
            wrPkt.regAddr <= byteShift_reg;
        end else if (byteDone && state_reg == ST_DATA) begin
            wrPkt.data <= byteShift_reg;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_ack_addr;
        writeCmd |-> ackDrive;
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");

    property p_ack_release;
        (ackDrive && sclFall && bitCnt_reg == ACK_SLOT && !startSeen) |=> !ackDrive;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack held past ninth clock");

    property p_wr_order;
        wrValid |-> state_reg == ST_DATA && $past(state_reg) == ST_DATA;
    endproperty
    a_wr_order: assert property (p_wr_order) else $error("data write out of order");

    c_write: cover property (wrValid);
endmodule : i2c_write_slave
`default_nettype wire

// *** hw/led_level_ramp.sv ***
// Brightness ramp stepping one code per step interval
`timescale 1ns/1ps
`default_nettype none
module led_level_ramp #(
    parameter int LEVEL_W = 7,
    parameter int STEP_CYCLES = flash_led_pkg::STEP_BASE_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] stepCode,
    input wire logic [LEVEL_W-1:0] target,
    output logic [LEVEL_W-1:0] level,
    output logic ramping
);
    import flash_led_pkg::*;

    localparam int CNT_W = $clog2(STEP_CYCLES * 8) + 1;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] interval;
    logic stepNow;

    assign interval = CNT_W'(STEP_CYCLES) << stepCode;
    assign stepNow = (level != target) && (cnt_reg == interval - CNT_W'(1));

    always_ff @(posedge clk) begin
        if (sys_rst || level == target || stepNow) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level <= '0;
        end else if (stepNow) begin
            level <= (level < target) ? level + LEVEL_W'(1) : level - LEVEL_W'(1);
        end
        ramping <= !sys_rst && (level != target);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_one_step;
        $changed(level) |-> (level == $past(level) + LEVEL_W'(1)) || (level == $past(level) - LEVEL_W'(1));
    endproperty
    a_one_step: assert property (p_one_step) else $error("level jumped by more than one");

    property p_step_time;
        $changed(level) |-> $past(cnt_reg) == $past(interval) - CNT_W'(1);
    endproperty
    a_step_time: assert property (p_step_time) else $error("step before interval elapsed");

    c_ramp_done: cover property ($fell(ramping));
endmodule : led_level_ramp
`default_nettype wire

// *** hw/flash_led_driver_control_regs.sv ***
// Control register bank of the dual-sink flash LED driver
`timescale 1ns/1ps
`default_nettype none
module flash_led_driver_control_regs #(
    parameter int STEP_CYCLES = flash_led_pkg::STEP_BASE_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,

    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,

    input wire logic mfIn,
    output logic mfOut,
    output logic mfOe,
    output logic pinResetMode,

    output logic sinkOneEn,
    output logic sinkTwoEn,
    output logic indicatorCurrent,
    output logic boostActive,
    output logic feedbackLow,
    output logic ovpHigh,
    output logic currentLimitLow,
    output logic [6:0] sinkLevel,
    output logic rampActive,
    output logic [3:0] flashTimeoutCode
);
    import flash_led_pkg::*;

    logic [7:0] regFile [NUM_REGS];

    reg_write_t wrPkt;
    logic wrValid;
    logic writeCmd;
    logic ackDrive;

    logic [6:0] rampTarget;
    logic [6:0] rampLevel;
    logic rampBusy;

    led_mode_t ledMode;
    logic boostBit;
    logic pinFunc;
    logic pinDir;
    logic hwReset;
    logic gpiCapture;

    i2c_write_slave u_slave (
        .clk(clk),
        .sys_rst(sys_rst),
        .scl(scl),
        .sdaIn(sdaIn),
        .ackDrive(ackDrive),
        .writeCmd(writeCmd),
        .wrValid(wrValid),
        .wrPkt(wrPkt)
    );

    led_level_ramp #(
        .LEVEL_W(7),
        .STEP_CYCLES(STEP_CYCLES)
    ) u_ramp (
        .clk(clk),
        .sys_rst(sys_rst),
        .stepCode(regFile[IDX_STEP][STEP_W-1:0]),
        .target(rampTarget),
        .level(rampLevel),
        .ramping(rampBusy)
    );

    // Open-drain data line, only ever pulled low
    assign sdaOut = 1'b0;
    assign sdaOe = ackDrive;
    assign rampActive = rampBusy;

    assign ledMode = led_mode_t'(regFile[IDX_GENERAL][MODE_MSB:MODE_LSB]);
    assign boostBit = regFile[IDX_GENERAL][BOOST_BIT];
    assign pinFunc = regFile[IDX_PIN][PIN_FUNC_BIT];
    assign pinDir = regFile[IDX_PIN][PIN_DIR_BIT];

    // Pin low while in reset function holds the bank at defaults
    assign hwReset = !pinFunc && !mfIn;

    assign gpiCapture = writeCmd && pinFunc && !pinDir;

    // One register per offset; fixed bits always reload
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
        always_ff @(posedge clk) begin
            if (sys_rst || hwReset) begin
                regFile[i] <= REG_RESET[i];
            end else if (wrValid && wrPkt.regAddr == REG_OFS[i]) begin
                regFile[i] <= (wrPkt.data & WMASK[i]) | (REG_RESET[i] & ~WMASK[i]);
            end else if (i == IDX_PIN && gpiCapture) begin
                regFile[i][PIN_DATA_BIT] <= mfIn;
            end
        end
    end

    // Ramp aims at flash or torch code, zero in other modes; starts from present level
    always_comb begin
        case (ledMode)
            MODE_FLASH: rampTarget = regFile[IDX_FLASH][FLASH_W-1:0];
            MODE_TORCH: rampTarget = {2'h0, regFile[IDX_TORCH][TORCH_W-1:0]};
            default: rampTarget = 7'h00;
        endcase
    end

    // Sink enables and boost mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sinkOneEn <= 1'b0;
            sinkTwoEn <= 1'b0;
            indicatorCurrent <= 1'b0;
            boostActive <= 1'b0;
        end else begin
            sinkOneEn <= (ledMode != MODE_OFF);
            sinkTwoEn <= (ledMode == MODE_TORCH) || (ledMode == MODE_FLASH);
            indicatorCurrent <= (ledMode == MODE_INDICATOR);
            boostActive <= boostBit && (ledMode == MODE_OFF);
        end
    end

    // Analog option selects
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            feedbackLow <= 1'b0;
            ovpHigh <= 1'b0;
            currentLimitLow <= 1'b0;
            flashTimeoutCode <= REG_RESET[IDX_TIMEOUT][TIMEOUT_W-1:0];
        end else begin
            feedbackLow <= regFile[IDX_GENERAL][FB_BIT];
            ovpHigh <= regFile[IDX_PIN][OVP_BIT];
            currentLimitLow <= regFile[IDX_PIN][OCL_BIT];
            flashTimeoutCode <= regFile[IDX_TIMEOUT][TIMEOUT_W-1:0];
        end
    end

    // Multi-function pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mfOe <= 1'b0;
            mfOut <= 1'b0;
            pinResetMode <= 1'b1;
        end else begin
            mfOe <= pinFunc && pinDir;
            mfOut <= regFile[IDX_PIN][PIN_DATA_BIT];
            pinResetMode <= !pinFunc;
        end
    end

    // Level code; lowest codes share one floor current
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sinkLevel <= MIN_LEVEL_CODE;
        end else begin
            sinkLevel <= (rampLevel < MIN_LEVEL_CODE) ? MIN_LEVEL_CODE : rampLevel;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_reset_vals;
        $past(sys_rst) |-> regFile[IDX_GENERAL] == 8'h18 && regFile[IDX_PIN] == 8'hE0
            && regFile[IDX_STEP] == 8'hFC && regFile[IDX_FLASH] == 8'h80;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("power-on value wrong");

    property p_indicator;
        ledMode == MODE_INDICATOR |=> sinkOneEn && !sinkTwoEn && indicatorCurrent;
    endproperty
    a_indicator: assert property (p_indicator) else $error("indicator sinks wrong");

    property p_boost_off;
        (boostBit && ledMode == MODE_OFF) |=> boostActive && !sinkOneEn && !sinkTwoEn;
    endproperty
    a_boost_off: assert property (p_boost_off) else $error("boost mode did not stop sinks");

    property p_boost_no_override;
        (boostBit && ledMode != MODE_OFF) |=> !boostActive && sinkOneEn;
    endproperty
    a_boost_no_override: assert property (p_boost_no_override) else $error("boost overrode mode");

    property p_feedback;
        ##1 feedbackLow == $past(regFile[IDX_GENERAL][FB_BIT]);
    endproperty
    a_feedback: assert property (p_feedback) else $error("feedback select lags");

    property p_pin_out;
        (pinFunc && pinDir) |=> mfOe && mfOut == $past(regFile[IDX_PIN][PIN_DATA_BIT]);
    endproperty
    a_pin_out: assert property (p_pin_out) else $error("output pin not driven from data");

    property p_gpi_capture;
        (writeCmd && pinFunc && !pinDir) |=> regFile[IDX_PIN][PIN_DATA_BIT] == $past(mfIn);
    endproperty
    a_gpi_capture: assert property (p_gpi_capture) else $error("pin level not captured");

    property p_fixed_bits;
        (regFile[IDX_GENERAL] & ~WMASK[IDX_GENERAL]) == (REG_RESET[IDX_GENERAL] & ~WMASK[IDX_GENERAL])
            && (regFile[IDX_TORCH] & ~WMASK[IDX_TORCH]) == (REG_RESET[IDX_TORCH] & ~WMASK[IDX_TORCH]);
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bit changed");

    property p_floor;
        sinkLevel >= MIN_LEVEL_CODE;
    endproperty
    a_floor: assert property (p_floor) else $error("level below floor");

    property p_hw_reset;
        hwReset |=> regFile[IDX_GENERAL] == 8'h18 && !mfOe;
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("pin reset ignored");

    property p_pin_input;
        (pinFunc && !pinDir) |=> !mfOe && !pinResetMode;
    endproperty
    a_pin_input: assert property (p_pin_input) else $error("input pin driven");

    property p_pin_reset_mode;
        !pinFunc |=> pinResetMode && !mfOe;
    endproperty
    a_pin_reset_mode: assert property (p_pin_reset_mode) else $error("reset function lost");

    property p_ovp;
        ##1 ovpHigh == $past(regFile[IDX_PIN][OVP_BIT]);
    endproperty
    a_ovp: assert property (p_ovp) else $error("overvoltage select lags");

    property p_current_limit;
        ##1 currentLimitLow == $past(regFile[IDX_PIN][OCL_BIT]);
    endproperty
    a_current_limit: assert property (p_current_limit) else $error("current limit select lags");

    property p_timeout;
        ##1 flashTimeoutCode == $past(regFile[IDX_TIMEOUT][TIMEOUT_W-1:0]);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout code lags");

    property p_mode_off;
        ledMode == MODE_OFF |=> !sinkOneEn && !sinkTwoEn && !indicatorCurrent;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("sinks on in shutdown");

    property p_torch_flash;
        (ledMode == MODE_TORCH || ledMode == MODE_FLASH) |=> sinkOneEn && sinkTwoEn && !indicatorCurrent;
    endproperty
    a_torch_flash: assert property (p_torch_flash) else $error("sinks wrong in torch or flash");

    property p_level_follow;
        rampLevel >= MIN_LEVEL_CODE |=> sinkLevel == $past(rampLevel);
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("level code not passed on");

    property p_level_floor;
        rampLevel < MIN_LEVEL_CODE |=> sinkLevel == MIN_LEVEL_CODE;
    endproperty
    a_level_floor: assert property (p_level_floor) else $error("low code not held at floor");

    property p_no_rise;
        (ledMode == MODE_OFF || ledMode == MODE_INDICATOR) |=> rampLevel <= $past(rampLevel);
    endproperty
    a_no_rise: assert property (p_no_rise) else $error("level rose while not lit");

    property p_busy;
        rampLevel != rampTarget |=> rampBusy;
    endproperty
    a_busy: assert property (p_busy) else $error("ramp not flagged");

    property p_torch_write;
        (wrValid && !hwReset && wrPkt.regAddr == REG_OFS[IDX_TORCH])
            |=> regFile[IDX_TORCH][TORCH_W-1:0] == $past(wrPkt.data[TORCH_W-1:0]);
    endproperty
    a_torch_write: assert property (p_torch_write) else $error("torch code not stored");

    property p_flash_write;
        (wrValid && !hwReset && wrPkt.regAddr == REG_OFS[IDX_FLASH])
            |=> regFile[IDX_FLASH][FLASH_W-1:0] == $past(wrPkt.data[FLASH_W-1:0]);
    endproperty
    a_flash_write: assert property (p_flash_write) else $error("flash code not stored");

    property p_unmapped;
        (wrValid && !hwReset && wrPkt.regAddr == 8'h30)
            |=> $stable(regFile[IDX_GENERAL]) && $stable(regFile[IDX_PIN]);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write landed");

    property p_fixed_other;
        (regFile[IDX_STEP] & ~WMASK[IDX_STEP]) == (REG_RESET[IDX_STEP] & ~WMASK[IDX_STEP])
            && (regFile[IDX_FLASH] & ~WMASK[IDX_FLASH]) == (REG_RESET[IDX_FLASH] & ~WMASK[IDX_FLASH]);
    endproperty
    a_fixed_other: assert property (p_fixed_other) else $error("fixed bit changed in step or flash");

    property p_reset_rest;
        $past(sys_rst) |-> regFile[IDX_TORCH] == 8'h80 && regFile[IDX_TIMEOUT] == 8'hF0;
    endproperty
    a_reset_rest: assert property (p_reset_rest) else $error("power-on torch or timeout wrong");

    c_flash: cover property (ledMode == MODE_FLASH && rampBusy);
    c_gpo: cover property (mfOe && mfOut);
    c_boost: cover property (boostActive);
endmodule : flash_led_driver_control_regs
`default_nettype wire

// *** bench/i2c_master_model.sv ***
// Two-wire bus master model that issues register writes
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input wire logic clk,
    input wire logic sdaWire,
    output var logic scl,
    output var logic sdaMst
);
    localparam int HALF = 3;

    initial begin
        scl = 1'b1;
        sdaMst = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold

    // Data changes only while the clock is low
    task automatic put_bit(input logic b, output logic seen);
        @(posedge clk);
        sdaMst <= b;
        hold(HALF);
        scl <= 1'b1;
        hold(HALF);
        seen = sdaWire;
        scl <= 1'b0;
    endtask : put_bit

    // Eight bits then a released acknowledge slot
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
    endtask : put_byte

    task automatic write(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d, input int n,
                         output logic [2:0] acks);
        acks = 3'h0;
        @(posedge clk);
        sdaMst <= 1'b1;
        scl <= 1'b1;
        hold(HALF);
        sdaMst <= 1'b0;
        hold(HALF);
        scl <= 1'b0;
        put_byte(a, acks[2]);
        if (n > 1) begin
            put_byte(r, acks[1]);
        end
        if (n > 2) begin
            put_byte(d, acks[0]);
        end
        @(posedge clk);
        sdaMst <= 1'b0;
        hold(HALF);
        scl <= 1'b1;
        hold(HALF);
        sdaMst <= 1'b1;
        hold(HALF);
    endtask : write
endmodule : i2c_master_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the flash LED control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin nChecks++; if ((got) !== (exp)) begin nErrors++; \
    $display("[FAIL] %s expected %h seen %h", name, exp, got); end end
module tb_top;
    import flash_led_pkg::*;
    localparam int STEP = 4;
    logic clk, sysRst, mfIn, scl, sdaMst;
    wire logic sdaWire;
    logic sdaOut, sdaOe, mfOut, mfOe, pinResetMode, sinkOneEn, sinkTwoEn, indicatorCurrent;
    logic boostActive, feedbackLow, ovpHigh, currentLimitLow, rampActive;
    logic [6:0] sinkLevel;
    logic [3:0] flashTimeoutCode;
    logic [7:0] shadow [NUM_REGS];
    logic [2:0] acks;
    logic [7:0] rnd;
    int nErrors = 0;
    int nChecks = 0;

    // Open-drain data line with pull-up
    assign sdaWire = (sdaOe && !sdaOut) ? 1'b0 : sdaMst;

    flash_led_driver_control_regs #(.STEP_CYCLES(STEP)) flash_led_driver_control_regs_inst (
        .clk(clk), .sys_rst(sysRst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .mfIn(mfIn), .mfOut(mfOut), .mfOe(mfOe), .pinResetMode(pinResetMode), .sinkOneEn(sinkOneEn),
        .sinkTwoEn(sinkTwoEn), .indicatorCurrent(indicatorCurrent), .boostActive(boostActive),
        .feedbackLow(feedbackLow), .ovpHigh(ovpHigh), .currentLimitLow(currentLimitLow),
        .sinkLevel(sinkLevel), .rampActive(rampActive), .flashTimeoutCode(flashTimeoutCode)
    );

    i2c_master_model i2c_master_model_inst (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaMst(sdaMst));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (40000) @(posedge clk);
        nErrors++;
        $display("[FAIL] watchdog expired");
        conclude();
    end

    task automatic check_all();
        logic [1:0] m;
        m = shadow[IDX_GENERAL][1:0];
        `CHK("sinkOneEn", m != 2'h0, sinkOneEn)
        `CHK("sinkTwoEn", m[1], sinkTwoEn)
        `CHK("indicatorCurrent", m == 2'h1, indicatorCurrent)
        `CHK("boostActive", shadow[IDX_GENERAL][2] && m == 2'h0, boostActive)
        `CHK("feedbackLow", shadow[IDX_GENERAL][5], feedbackLow)
        `CHK("pinResetMode", !shadow[IDX_PIN][0], pinResetMode)
        `CHK("mfOe", shadow[IDX_PIN][0] && shadow[IDX_PIN][1], mfOe)
        `CHK("mfOut", shadow[IDX_PIN][2], mfOut)
        `CHK("ovpHigh", shadow[IDX_PIN][3], ovpHigh)
        `CHK("currentLimitLow", shadow[IDX_PIN][4], currentLimitLow)
        `CHK("flashTimeoutCode", shadow[IDX_TIMEOUT][3:0], flashTimeoutCode)
    endtask : check_all

    function automatic logic [7:0] merged(input logic [7:0] old, input logic [7:0] d, input logic [7:0] m);
        return (old & ~m) | (d & m);
    endfunction : merged

    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        // Input pin level lands in the data bit on each write
        if (shadow[IDX_PIN][0] && !shadow[IDX_PIN][1]) begin
            shadow[IDX_PIN][2] = mfIn;
        end
        for (int i = 0; i < NUM_REGS; i++) begin
            if (r == REG_OFS[i]) begin
                shadow[i] = merged(shadow[i], d, WMASK[i]);
            end
        end
        i2c_master_model_inst.write(8'hA6, r, d, 3, acks);
        `CHK("ack", 3'h7, acks)
        repeat (3) @(posedge clk);
    endtask : wr

    task automatic ramp_to(input logic [1:0] code, input logic [1:0] mode, input logic [6:0] tgt);
        logic [6:0] last;
        int gap;
        int changes;
        logic busySeen;
        wr(8'h50, {6'h3F, code});
        wr(8'h10, {6'h06, mode});
        check_all();
        last = sinkLevel;
        gap = 0;
        changes = 0;
        busySeen = rampActive;
        for (int k = 0; k < 5000 && sinkLevel !== tgt; k++) begin
            @(posedge clk);
            gap++;
            busySeen = busySeen | rampActive;
            if (sinkLevel !== last) begin
                `CHK("stepSize", 1'b1, sinkLevel == last + 7'h01 || sinkLevel + 7'h01 == last)
                if (changes > 0) begin
                    `CHK("stepGap", STEP << code, gap)
                end
                changes++;
                gap = 0;
                last = sinkLevel;
            end
        end
        `CHK("rampEnd", tgt, sinkLevel)
        `CHK("rampBusy", 1'b1, busySeen)
        repeat (STEP * 40 + 4) @(posedge clk);
        `CHK("rampIdle", 1'b0, rampActive)
        `CHK("rampHold", tgt, sinkLevel)
    endtask : ramp_to

    initial begin
        rnd = 8'($urandom(32'h6CB6));
        sysRst <= 1'b1;
        mfIn <= 1'b1;
        for (int i = 0; i < NUM_REGS; i++) begin
            shadow[i] = REG_RESET[i];
        end
        repeat (4) @(posedge clk);
        sysRst <= 1'b0;
        repeat (3) @(posedge clk);
        check_all();
        `CHK("sinkLevel", 7'h04, sinkLevel)
        // Wrong address and read direction are not answered
        i2c_master_model_inst.write(8'hA4, 8'h10, 8'h03, 3, acks);
        `CHK("ackWrongAddr", 3'h0, acks)
        i2c_master_model_inst.write(8'hA7, 8'h10, 8'h03, 3, acks);
        `CHK("ackRead", 3'h0, acks)
        check_all();
        wr(8'h30, 8'hFF);
        check_all();
        for (int i = 0; i < 8; i++) begin
            rnd = 8'($urandom);
            wr(8'h10, {2'h0, rnd[5], 2'h3, 3'(i)});
            check_all();
            `CHK("floor", 7'h04, sinkLevel)
        end
        wr(8'h10, 8'hFF);
        check_all();
        wr(8'h10, 8'h18);
        // Leave reset function first, then select output
        wr(8'h20, 8'h01);
        check_all();
        wr(8'h20, 8'h07);
        check_all();
        wr(8'h20, 8'h03);
        check_all();
        wr(8'h20, 8'h1B);
        check_all();
        wr(8'h20, 8'h11);
        wr(8'h50, 8'h01);
        check_all();
        mfIn <= 1'b0;
        @(posedge clk);
        wr(8'h50, 8'h02);
        check_all();
        mfIn <= 1'b1;
        @(posedge clk);
        wr(8'h20, 8'h08);
        check_all();
        wr(8'h10, 8'h1B);
        mfIn <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < NUM_REGS; i++) begin
            shadow[i] = REG_RESET[i];
        end
        check_all();
        mfIn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rnd = 8'($urandom);
            wr(8'hC0, rnd);
            check_all();
        end
        wr(8'hC0, 8'hFF);
        check_all();
        wr(8'hA0, 8'hFF);
        ramp_to(2'h0, 2'h2, 7'h1F);
        rnd = 8'($urandom_range(127, 40));
        wr(8'hB0, {1'b1, rnd[6:0]});
        ramp_to(2'h1, 2'h3, rnd[6:0]);
        ramp_to(2'h3, 2'h0, 7'h04);
        wr(8'hB0, 8'hFF);
        ramp_to(2'h0, 2'h3, 7'h7F);
        ramp_to(2'h2, 2'h0, 7'h04);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
